/* File: include/ddc_pkg.sv */
// Purpose: Shared constants and types for the disk drive control port.
// Assumes: 50 MHz system clock, 32-bit register port with byte offsets.
// Notes:   Register offsets and step timing are local choices.
package ddc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CYL_W  = 16;
  localparam int HEAD_W = 4;
  localparam int CMD_W  = 3;
  localparam int RTY_W  = 8;
  localparam int TM_W   = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HEAD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RWC    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CYL    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RETRY  = 8'h1C;

  // Control register fields
  localparam int CTRL_UNIT   = 0;
  localparam int CTRL_SEL_EN = 1;

  // Status register fields
  localparam int ST_BUSY      = 0;
  localparam int ST_READY     = 1;
  localparam int ST_SEEK_DONE = 2;
  localparam int ST_TRK0      = 3;
  localparam int ST_FAULT     = 4;
  localparam int ST_INDEX     = 5;
  localparam int ST_STICKY    = 6;
  localparam int STICKY_W     = 4;
  localparam int ST_RWC       = 10;

  // Sticky flag positions inside the sticky group
  localparam int SK_DONE    = 0;
  localparam int SK_FAULT   = 1;
  localparam int SK_TIMEOUT = 2;
  localparam int SK_REFUSED = 3;

  // Reset values
  localparam logic [CYL_W-1:0] RWC_RST   = 16'hFFFF;
  localparam logic [RTY_W-1:0] RETRY_RST = 8'h08;

  // ----------------------------------------------------------------
  // Commands written to the command register
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_SEEK   = 3'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE  = 3'h2;
  localparam logic [CMD_W-1:0] CMD_READ   = 3'h3;
  localparam logic [CMD_W-1:0] CMD_FORMAT = 3'h4;
  localparam logic [CMD_W-1:0] CMD_RECAL  = 3'h5;
  localparam logic [CMD_W-1:0] CMD_ABORT  = 3'h6;

  // Step direction levels on the cable
  localparam logic DIR_IN  = 1'b0;
  localparam logic DIR_OUT = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int STEP_HI_US  = 8;
  localparam int STEP_GAP_US = 17;
  localparam int STEP_HI_CYC  = STEP_HI_US * CLK_MHZ;
  localparam int STEP_GAP_CYC = STEP_GAP_US * CLK_MHZ;
  localparam int MAX_STEPS    = 1024;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic seek_complete;
    logic track_zero;
    logic write_fault;
    logic index;
    logic drive_ready;
  } ddc_drv_in_t;

  typedef struct packed {
    logic [HEAD_W-1:0] head_sel;
    logic              reduce_write_current;
    logic              write_gate;
    logic              step;
    logic              step_direction;
    logic              unit_select_0;
    logic              unit_select_1;
  } ddc_drv_out_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_DECIDE,
    S_STEP_GAP,
    S_STEP_HI,
    S_SETTLE,
    S_WRITE,
    S_READ,
    S_FMT_WAIT,
    S_FMT_WRITE
  } ddc_state_t;

endpackage : ddc_pkg

/* File: hw/ddc_sync.sv */
// Purpose: Two-stage synchroniser for the drive status lines.
// Assumes: Inputs are asynchronous levels from the cable.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module ddc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("ddc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else if (clk_en) begin
      meta <= d_async;
      q    <= meta;
    end
  end

endmodule : ddc_sync

/* File: hw/ddc_port.sv */
// Purpose: Drive control side of a two-drive disk controller: select, head, step, write gate.
// Assumes: Drive lines are asynchronous; data path signals share clk_sys.
// Notes:   Transfers seek to the target cylinder first, then wait for seek complete.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Drive four-bit head number to drives
// - Reduce write current from configured cylinder onward
// - Write gate only while valid data written
// - Drop write gate at once on fault
// - Fault aborts command, refuses new ones
// - Index syncs formatting and times retries
// - One step pulse per cylinder crossed
// - Direction low inward, high outward
// - Select line zero drive 0, one drive 1
// - Only addressed drive acts on shared lines
module ddc_port #(
  parameter int STEP_HI_CYC  = ddc_pkg::STEP_HI_CYC,
  parameter int STEP_GAP_CYC = ddc_pkg::STEP_GAP_CYC,
  parameter int MAX_STEPS    = ddc_pkg::MAX_STEPS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic [ddc_pkg::ADDR_W-1:0]  bus_addr,
  input  wire logic [ddc_pkg::DATA_W-1:0]  bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic      [ddc_pkg::DATA_W-1:0]  bus_rdata,
  input  wire ddc_pkg::ddc_drv_in_t        drv_in,
  output ddc_pkg::ddc_drv_out_t            drv_out,
  input  wire logic                        wr_data_valid,
  input  wire logic                        wr_done,
  input  wire logic                        rd_done,
  output logic                             xfer_write,
  output logic                             xfer_read
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (STEP_HI_CYC < 1 || STEP_HI_CYC >= (1 << ddc_pkg::TM_W) || STEP_GAP_CYC < 1 ||
      STEP_GAP_CYC >= (1 << ddc_pkg::TM_W) || MAX_STEPS < 1 || MAX_STEPS >= (1 << ddc_pkg::CYL_W)) begin : g_chk
    $error("ddc_port: timing parameter out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ddc_pkg::ddc_drv_in_t           drv_s;
  ddc_pkg::ddc_state_t            state, next_state;
  logic [ddc_pkg::HEAD_W-1:0]     head;
  logic [ddc_pkg::CYL_W-1:0]      rwc_cyl, target_cyl, cur_cyl, step_total;
  logic [ddc_pkg::RTY_W-1:0]      retry_limit, idx_cnt;
  logic [ddc_pkg::TM_W-1:0]       tm;
  logic [ddc_pkg::CMD_W-1:0]      op, cmd_code;
  logic [ddc_pkg::STICKY_W-1:0]   sticky, sticky_set, sticky_clr;
  logic                           ctrl_unit, ctrl_sel_en, dir, idx_d, index_rise, fault, ready, busy;
  logic                           cmd_wr, cmd_xfer, cmd_abort, start, refuse, step_end, timeout;
  logic                           done_evt, gate_req;

  // ----------------------------------------------------------------
  // Drive input synchronisation
  // ----------------------------------------------------------------
  ddc_sync #(.WIDTH($bits(ddc_pkg::ddc_drv_in_t))) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d_async (drv_in),
    .q       (drv_s)
  );

  // Drive inputs count only while a unit is selected, since a deselected drive may not answer
  assign index_rise = ctrl_sel_en & drv_s.index & ~idx_d;
  assign fault      = ctrl_sel_en & drv_s.write_fault;
  assign ready      = ctrl_sel_en & drv_s.drive_ready;
  assign busy       = (state != ddc_pkg::S_IDLE);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd_wr    = bus_wr && (bus_addr == ddc_pkg::OFS_CMD);
  assign cmd_code  = bus_wdata[ddc_pkg::CMD_W-1:0];
  assign cmd_abort = cmd_wr && (cmd_code == ddc_pkg::CMD_ABORT);
  assign cmd_xfer  = cmd_wr && (cmd_code >= ddc_pkg::CMD_SEEK) && (cmd_code <= ddc_pkg::CMD_RECAL);
  // Refused while a fault stands or the drive is not up to speed
  assign refuse    = cmd_xfer && !busy && (fault || !ready);
  assign start     = cmd_xfer && !busy && !fault && ready;

  assign step_end  = (state == ddc_pkg::S_STEP_HI) && (tm == ddc_pkg::TM_W'(STEP_HI_CYC - 1));
  // Revolutions serve as the time base for giving up
  assign timeout   = busy && (idx_cnt > retry_limit);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    done_evt   = 1'b0;
    case (state)
      ddc_pkg::S_IDLE: begin
        if (start) begin
          next_state = ddc_pkg::S_DECIDE;
        end
      end
      ddc_pkg::S_DECIDE: begin
        if (op == ddc_pkg::CMD_RECAL) begin
          next_state = drv_s.track_zero ? ddc_pkg::S_SETTLE : ddc_pkg::S_STEP_GAP;
        end else if (cur_cyl == target_cyl) begin
          next_state = ddc_pkg::S_SETTLE;
        end else begin
          next_state = ddc_pkg::S_STEP_GAP;
        end
      end
      ddc_pkg::S_STEP_GAP: begin
        // Track zero arrives late through the synchroniser; stop here so no pulse goes past it
        if (op == ddc_pkg::CMD_RECAL && drv_s.track_zero) begin
          next_state = ddc_pkg::S_SETTLE;
        end else if (tm == ddc_pkg::TM_W'(STEP_GAP_CYC - 1)) begin
          next_state = ddc_pkg::S_STEP_HI;
        end
      end
      ddc_pkg::S_STEP_HI: begin
        if (step_end) begin
          next_state = ddc_pkg::S_DECIDE;
        end
      end
      ddc_pkg::S_SETTLE: begin
        if (drv_s.seek_complete) begin
          if (op == ddc_pkg::CMD_WRITE) begin
            next_state = ddc_pkg::S_WRITE;
          end else if (op == ddc_pkg::CMD_READ) begin
            next_state = ddc_pkg::S_READ;
          end else if (op == ddc_pkg::CMD_FORMAT) begin
            next_state = ddc_pkg::S_FMT_WAIT;
          end else begin
            next_state = ddc_pkg::S_IDLE;
            done_evt   = 1'b1;
          end
        end
      end
      ddc_pkg::S_WRITE: begin
        if (wr_done) begin
          next_state = ddc_pkg::S_IDLE;
          done_evt   = 1'b1;
        end
      end
      ddc_pkg::S_READ: begin
        if (rd_done) begin
          next_state = ddc_pkg::S_IDLE;
          done_evt   = 1'b1;
        end
      end
      ddc_pkg::S_FMT_WAIT: begin
        if (index_rise) begin
          next_state = ddc_pkg::S_FMT_WRITE;
        end
      end
      ddc_pkg::S_FMT_WRITE: begin
        if (index_rise) begin
          next_state = ddc_pkg::S_IDLE;
          done_evt   = 1'b1;
        end
      end
      default: begin
        next_state = ddc_pkg::S_IDLE;
      end
    endcase
    // Fault, abort, timeout and a step count reaching MAX_STEPS on any command all end the command
    if (busy && (fault || cmd_abort || timeout || step_total >= ddc_pkg::CYL_W'(MAX_STEPS))) begin
      next_state = ddc_pkg::S_IDLE;
      done_evt   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ddc_pkg::S_IDLE;
      op    <= ddc_pkg::CMD_SEEK;
    end else if (clk_en) begin
      state <= next_state;
      if (start) begin
        op <= cmd_code;
      end
    end
  end

  // Shared timer for step gap and pulse width
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tm <= '0;
    end else if (clk_en) begin
      tm <= (next_state != state) ? '0 : tm + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idx_cnt <= '0;
      idx_d   <= 1'b0;
    end else if (clk_en) begin
      idx_d <= drv_s.index;
      if (next_state != state || !busy) begin
        idx_cnt <= '0;
      end else if (index_rise && idx_cnt != '1) begin
        idx_cnt <= idx_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Head position tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir <= ddc_pkg::DIR_IN;
    end else if (clk_en && state == ddc_pkg::S_DECIDE) begin
      // Direction settles a full gap before the pulse and holds through it
      if (op == ddc_pkg::CMD_RECAL || target_cyl < cur_cyl) begin
        dir <= ddc_pkg::DIR_OUT;
      end else begin
        dir <= ddc_pkg::DIR_IN;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur_cyl    <= '0;
      step_total <= '0;
    end else if (clk_en) begin
      step_total <= start ? '0 : step_total + ddc_pkg::CYL_W'(step_end);
      if (next_state == ddc_pkg::S_SETTLE && op == ddc_pkg::CMD_RECAL && drv_s.track_zero) begin
        cur_cyl <= '0;
      end else if (step_end) begin
        // Each pulse moves one cylinder, except an outward pulse at cylinder zero, which leaves the count at zero
        if (dir == ddc_pkg::DIR_IN) begin
          cur_cyl <= cur_cyl + 1'b1;
        end else if (cur_cyl != '0) begin
          cur_cyl <= cur_cyl - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_unit   <= 1'b0;
      ctrl_sel_en <= 1'b0;
      head        <= '0;
      rwc_cyl     <= ddc_pkg::RWC_RST;
      target_cyl  <= '0;
      retry_limit <= ddc_pkg::RETRY_RST;
    end else if (clk_en && bus_wr) begin
      // Unit and target stay frozen while a command runs
      if (bus_addr == ddc_pkg::OFS_CTRL && !busy) begin
        ctrl_unit   <= bus_wdata[ddc_pkg::CTRL_UNIT];
        ctrl_sel_en <= bus_wdata[ddc_pkg::CTRL_SEL_EN];
      end else if (bus_addr == ddc_pkg::OFS_HEAD) begin
        head <= bus_wdata[ddc_pkg::HEAD_W-1:0];
      end else if (bus_addr == ddc_pkg::OFS_RWC) begin
        rwc_cyl <= bus_wdata[ddc_pkg::CYL_W-1:0];
      end else if (bus_addr == ddc_pkg::OFS_TARGET && !busy) begin
        target_cyl <= bus_wdata[ddc_pkg::CYL_W-1:0];
      end else if (bus_addr == ddc_pkg::OFS_RETRY) begin
        retry_limit <= bus_wdata[ddc_pkg::RTY_W-1:0];
      end
    end
  end

  // Sticky flags: write one to clear; a new event in the same cycle wins
  always_comb begin
    sticky_set = '0;
    sticky_set[ddc_pkg::SK_DONE]    = done_evt;
    sticky_set[ddc_pkg::SK_FAULT]   = busy && fault;
    sticky_set[ddc_pkg::SK_TIMEOUT] = timeout;
    sticky_set[ddc_pkg::SK_REFUSED] = refuse;
    sticky_clr = '0;
    if (bus_wr && bus_addr == ddc_pkg::OFS_STATUS) begin
      sticky_clr = bus_wdata[ddc_pkg::ST_STICKY +: ddc_pkg::STICKY_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sticky <= '0;
    end else if (clk_en) begin
      sticky <= (sticky & ~sticky_clr) | sticky_set;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_rdata <= '0;
    end else if (clk_en) begin
      bus_rdata <= '0;
      if (bus_rd) begin
        if (bus_addr == ddc_pkg::OFS_CTRL) begin
          bus_rdata[ddc_pkg::CTRL_UNIT]   <= ctrl_unit;
          bus_rdata[ddc_pkg::CTRL_SEL_EN] <= ctrl_sel_en;
        end else if (bus_addr == ddc_pkg::OFS_HEAD) begin
          bus_rdata[ddc_pkg::HEAD_W-1:0] <= head;
        end else if (bus_addr == ddc_pkg::OFS_RWC) begin
          bus_rdata[ddc_pkg::CYL_W-1:0] <= rwc_cyl;
        end else if (bus_addr == ddc_pkg::OFS_TARGET) begin
          bus_rdata[ddc_pkg::CYL_W-1:0] <= target_cyl;
        end else if (bus_addr == ddc_pkg::OFS_STATUS) begin
          bus_rdata[ddc_pkg::ST_BUSY]      <= busy;
          bus_rdata[ddc_pkg::ST_READY]     <= ready;
          bus_rdata[ddc_pkg::ST_SEEK_DONE] <= ctrl_sel_en & drv_s.seek_complete;
          bus_rdata[ddc_pkg::ST_TRK0]      <= ctrl_sel_en & drv_s.track_zero;
          bus_rdata[ddc_pkg::ST_FAULT]     <= fault;
          bus_rdata[ddc_pkg::ST_INDEX]     <= ctrl_sel_en & drv_s.index;
          bus_rdata[ddc_pkg::ST_STICKY +: ddc_pkg::STICKY_W] <= sticky;
          bus_rdata[ddc_pkg::ST_RWC]       <= drv_out.reduce_write_current;
        end else if (bus_addr == ddc_pkg::OFS_CYL) begin
          bus_rdata[ddc_pkg::CYL_W-1:0] <= cur_cyl;
        end else if (bus_addr == ddc_pkg::OFS_RETRY) begin
          bus_rdata[ddc_pkg::RTY_W-1:0] <= retry_limit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Cable outputs
  // ----------------------------------------------------------------
  // Gate needs data and no fault; the fault term also cuts it in the cycle it is seen
  assign gate_req = (state == ddc_pkg::S_WRITE || state == ddc_pkg::S_FMT_WRITE) &&
                    (next_state == state) && wr_data_valid && !fault;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drv_out    <= '0;
      xfer_write <= 1'b0;
      xfer_read  <= 1'b0;
    end else if (clk_en) begin
      drv_out.unit_select_0        <= ctrl_sel_en & ~ctrl_unit;
      drv_out.unit_select_1        <= ctrl_sel_en & ctrl_unit;
      drv_out.head_sel             <= ctrl_sel_en ? head : '0;
      drv_out.reduce_write_current <= ctrl_sel_en && (cur_cyl >= rwc_cyl);
      drv_out.write_gate           <= ctrl_sel_en & gate_req;
      drv_out.step                 <= ctrl_sel_en && (next_state == ddc_pkg::S_STEP_HI);
      drv_out.step_direction       <= dir;
      xfer_write                   <= (next_state == ddc_pkg::S_WRITE) || (next_state == ddc_pkg::S_FMT_WRITE);
      xfer_read                    <= (next_state == ddc_pkg::S_READ);
    end
  end

endmodule : ddc_port

/* File: bench/ddc_sva.sv */
// Purpose: Concurrent checks on the drive control port pins.
// Assumes: clk_en held high; one clock domain.
// Notes:   Step width is measured by a helper counter.
`timescale 1ns/1ps
module ddc_sva #(
  parameter int STEP_HI_CYC = 2
) (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire ddc_pkg::ddc_drv_in_t  drv_in,
  input wire ddc_pkg::ddc_drv_out_t drv_out,
  input wire logic                  wr_data_valid,
  input wire logic                  xfer_write,
  input wire logic                  xfer_read
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] hi_cnt;
  logic        any_sel;
  assign any_sel = drv_out.unit_select_0 || drv_out.unit_select_1;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) hi_cnt <= 16'h0000;
    else hi_cnt <= drv_out.step ? hi_cnt + 16'h0001 : 16'h0000;
  end
  a_one_select: assert property (!(drv_out.unit_select_0 && drv_out.unit_select_1))
    else $error("both unit selects high");
  a_gate_valid: assert property (drv_out.write_gate |-> $past(wr_data_valid))
    else $error("write gate without valid data");
  a_gate_xfer: assert property (drv_out.write_gate |-> xfer_write || $past(xfer_write))
    else $error("write gate outside a write phase");
  a_fault_gate: assert property (drv_in.write_fault [*4] |-> !drv_out.write_gate)
    else $error("write gate kept during fault");
  a_fault_norun: assert property (drv_in.write_fault [*6] |-> !$rose(xfer_write) && !$rose(xfer_read))
    else $error("transfer started during fault");
  a_rwc_sel: assert property (drv_out.reduce_write_current |-> any_sel)
    else $error("reduced current with no unit");
  a_head_sel: assert property (drv_out.head_sel != 4'h0 |-> any_sel)
    else $error("head number with no unit");
  a_dir_stable: assert property (drv_out.step |-> $stable(drv_out.step_direction))
    else $error("direction moved during step");
  a_step_width: assert property ($fell(drv_out.step) |-> hi_cnt == 16'(STEP_HI_CYC))
    else $error("step pulse width wrong");
  cover property ($rose(drv_out.step));
  cover property ($rose(drv_out.write_gate));
  cover property ($rose(xfer_read));
endmodule : ddc_sva

bind ddc_port ddc_sva #(.STEP_HI_CYC(STEP_HI_CYC)) u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .drv_in(drv_in), .drv_out(drv_out), .wr_data_valid(wr_data_valid), .xfer_write(xfer_write),
  .xfer_read(xfer_read));

/* File: bench/ddc_drive_model.sv */
// Purpose: Behavioural hard disk drive on the shared control cable.
// Assumes: An unselected drive releases its lines to the inactive level.
// Notes:   Settle time and revolution are shortened to keep runs brief.
`timescale 1ns/1ps
module ddc_drive_model #(
  parameter int UNIT  = 0,
  parameter int START = 0
) (
  input  wire logic                  clk_sys,
  input  wire ddc_pkg::ddc_drv_out_t drv_out,
  input  wire logic                  rdy,
  input  wire logic                  fault,
  output ddc_pkg::ddc_drv_in_t       drv,
  output logic [15:0]                cyl
);
  // ----------------------------------------------------------------
  // Head motion
  // ----------------------------------------------------------------
  logic        sel;
  logic        stp_q  = 1'b0;
  logic [3:0]  settle = 4'h0;
  logic [5:0]  tick   = 6'h00;
  logic [15:0] cyl_q  = 16'(START);
  assign cyl = cyl_q;
  assign sel = (UNIT == 0) ? drv_out.unit_select_0 : drv_out.unit_select_1;
  always_ff @(posedge clk_sys) begin
    stp_q <= drv_out.step;
    tick  <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
    if (sel && drv_out.step && !stp_q) begin
      cyl_q  <= drv_out.step_direction ? cyl_q - 16'h0001 : cyl_q + 16'h0001;
      settle <= 4'h6;
    end else if (settle != 4'h0) begin
      settle <= settle - 4'h1;
    end
  end
  // Terminated lines read inactive when this drive is not addressed
  assign drv = sel ? ddc_pkg::ddc_drv_in_t'({settle == 4'h0, cyl_q == 16'h0000, fault,
                                             tick == 6'h00, rdy}) : '0;
endmodule : ddc_drive_model

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the disk drive control port.
// Assumes: Two drive models share the control lines.
// Notes:   Short step timing keeps the run brief.
`timescale 1ns/1ps
module tb_top;
  logic                  clk_sys, sys_rst, ce, bus_wr, bus_rd, wdv, wr_done, rd_done, rdy, wf, xw, xr;
  logic [7:0]            bus_addr;
  logic [31:0]           bus_wdata, bus_rdata, st;
  logic [15:0]           cyl0, cyl1;
  ddc_pkg::ddc_drv_in_t  d0, d1, drv_in;
  ddc_pkg::ddc_drv_out_t drv_out;
  int                    n_mismatch, num_checks;
  assign drv_in = ddc_pkg::ddc_drv_in_t'(d0 | d1);
  ddc_port #(.STEP_HI_CYC(2), .STEP_GAP_CYC(3), .MAX_STEPS(16)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .drv_in(drv_in), .drv_out(drv_out), .wr_data_valid(wdv), .wr_done(wr_done),
    .rd_done(rd_done), .xfer_write(xw), .xfer_read(xr));
  ddc_drive_model m0 (.clk_sys(clk_sys), .drv_out(drv_out), .rdy(rdy), .fault(wf),
    .drv(d0), .cyl(cyl0));
  ddc_drive_model #(.UNIT(1), .START(3)) m1 (.clk_sys(clk_sys), .drv_out(drv_out), .rdy(rdy), .fault(wf),
    .drv(d1), .cyl(cyl1));
  // ----------------------------------------------------------------
  // Bus cycles and compares
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys); bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1;
    @(posedge clk_sys); bus_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys); bus_addr <= a; bus_rd <= 1'b1;
    @(posedge clk_sys); bus_rd <= 1'b0;
    #1 st = bus_rdata;
  endtask : rd
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task go(input logic [2:0] c, input logic [15:0] t);
    wr(ddc_pkg::OFS_STATUS, 32'h0000_03C0);
    wr(ddc_pkg::OFS_TARGET, {16'h0000, t});
    wr(ddc_pkg::OFS_CMD, {29'h0000_0000, c});
  endtask : go
  task wt;
    st = 32'h0000_0001;
    for (int i = 0; i < 400 && st[0] !== 1'b0; i++) rd(ddc_pkg::OFS_STATUS);
  endtask : wt
  task wbeg;
    go(ddc_pkg::CMD_WRITE, 16'h0001);
    for (int i = 0; i < 100 && xw !== 1'b1; i++) @(posedge clk_sys);
    wdv <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("gate", 32'h0000_0001, {31'h0, drv_out.write_gate});
  endtask : wbeg
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(ddc_pkg::OFS_RWC); chk("rwc_rst", 32'h0000_FFFF, st);
    rd(ddc_pkg::OFS_RETRY); chk("retry_rst", 32'h0000_0008, st);
    rd(8'h20); chk("unmapped", 32'h0000_0000, st);
  endtask : t_regs
  task t_seek;
    wr(ddc_pkg::OFS_CTRL, 32'h0000_0002); wr(ddc_pkg::OFS_RWC, 32'h0000_0003);
    go(ddc_pkg::CMD_SEEK, 16'h0005); wt; chk("done", 32'h0000_0040, st & 32'h0000_03C1);
    chk("m0cyl_in", 32'h0000_0005, {16'h0, cyl0});
    chk("rwc_on", 32'h0000_0001, {31'h0, drv_out.reduce_write_current});
    go(ddc_pkg::CMD_SEEK, 16'h0001); wt; chk("m0cyl_out", 32'h0000_0001, {16'h0, cyl0});
    chk("rwc_off", 32'h0000_0000, {31'h0, drv_out.reduce_write_current});
  endtask : t_seek
  task t_unit;
    wr(ddc_pkg::OFS_CTRL, 32'h0000_0003); wr(ddc_pkg::OFS_HEAD, 32'h0000_000A);
    repeat (2) @(posedge clk_sys);
    #1 chk("sel_head", 32'h0000_00A1, {24'h0, drv_out.head_sel, 2'b00, drv_out.unit_select_0,
                                        drv_out.unit_select_1});
    ce <= 1'b0; wr(ddc_pkg::OFS_HEAD, 32'h0000_0005); ce <= 1'b1; rd(ddc_pkg::OFS_HEAD); chk("frozen", 32'h0000_000A, st);
    go(ddc_pkg::CMD_RECAL, 16'h0000); wt; rd(ddc_pkg::OFS_CYL); chk("cyl_rcl", 32'h0000_0000, st);
    chk("m1cyl", 32'h0000_0000, {16'h0, cyl1});
    chk("m0kept", 32'h0000_0001, {16'h0, cyl0});
  endtask : t_unit
  task t_write;
    wr(ddc_pkg::OFS_CTRL, 32'h0000_0002); wbeg;
    @(posedge clk_sys); wr_done <= 1'b1; @(posedge clk_sys); wr_done <= 1'b0; wdv <= 1'b0;
    wt; chk("wr_done", 32'h0000_0040, st & 32'h0000_03C1);
    wbeg; wf <= 1'b1; repeat (4) @(posedge clk_sys);
    #1 chk("gate_flt", 32'h0000_0000, {31'h0, drv_out.write_gate});
    wt; chk("abort", 32'h0000_0080, st & 32'h0000_03C1);
    go(ddc_pkg::CMD_SEEK, 16'h0003); wt; chk("refuse_f", 32'h0000_0200, st & 32'h0000_03C1);
    wf <= 1'b0; wdv <= 1'b0; rdy <= 1'b0; repeat (4) @(posedge clk_sys);
    go(ddc_pkg::CMD_SEEK, 16'h0003); wt; chk("refuse_r", 32'h0000_0200, st & 32'h0000_03C1);
    rd(ddc_pkg::OFS_CYL); chk("cyl_kept", 32'h0000_0001, st);
    rdy <= 1'b1; repeat (4) @(posedge clk_sys);
  endtask : t_write
  task t_read;
    wr(ddc_pkg::OFS_RETRY, 32'h0000_0001); go(ddc_pkg::CMD_READ, 16'h0001);
    for (int i = 0; i < 100 && xr !== 1'b1; i++) @(posedge clk_sys);
    rd_done <= 1'b1; @(posedge clk_sys); rd_done <= 1'b0;
    wt; chk("rd_done", 32'h0000_0040, st & 32'h0000_03C1);
    go(ddc_pkg::CMD_READ, 16'h0001); wt; chk("timeout", 32'h0000_0100, st & 32'h0000_03C1);
    go(ddc_pkg::CMD_FORMAT, 16'h0001); wt; chk("format", 32'h0000_0040, st & 32'h0000_03C1);
  endtask : t_read
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    #400000 n_mismatch++;
    end_sim;
  end
  initial begin
    sys_rst = 1'b1; bus_wr = 1'b0; bus_rd = 1'b0; wdv = 1'b0; wr_done = 1'b0; rd_done = 1'b0;
    rdy = 1'b1; wf = 1'b0; ce = 1'b1; bus_addr = 8'h00; bus_wdata = 32'h0000_0000;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs; t_seek; t_unit; t_write; t_read;
    end_sim;
  end
endmodule : tb_top
